// ### src/quad_dac_serial_load_control.sv
// quad dac serial load control: input registers, dac registers and power-down state
// assumes: all pins are asynchronous to clk and are synchronised here; the
// converters themselves sit outside and take dac_code and chan_power_down
`default_nettype none
module quad_dac_serial_load_control #(
  parameter int NUM_CH = dac_ctrl_pkg::NUM_CH
) (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  // serial link pins
  input  wire logic                        cs_n,
  input  wire logic                        sclk,
  input  wire logic                        serial_in_power_down_pin,
  input  wire logic                        pin_float,
  // register control pins
  input  wire logic                        load_strobe_n,
  input  wire logic                        clear_n,
  // converter side
  output var  dac_ctrl_pkg::code_bank_type dac_code,
  output var  logic [NUM_CH-1:0]           chan_power_down,
  output var  logic                        hw_power_down,
  // observation of the input registers
  output var  dac_ctrl_pkg::code_bank_type input_code
);

  typedef struct packed {
    dac_ctrl_pkg::code_bank_type in_reg;
    dac_ctrl_pkg::code_bank_type dac_reg;
    logic [NUM_CH-1:0]           sw_pd;
    logic                        hw_pd;
    logic [NUM_CH-1:0]           chan_pd;
  } ctrl_state_type;

  ctrl_state_type          state_ff;
  ctrl_state_type          nxt_state;
  dac_ctrl_pkg::pin_type   pins_raw;
  dac_ctrl_pkg::pin_type   pins;
  dac_ctrl_pkg::frame_type frame;
  logic                    frame_valid;
  logic [1:0]              frame_addr;
  logic [NUM_CH-1:0]       frame_sel;

  if (NUM_CH != (1 << dac_ctrl_pkg::ADDR_W)) begin : g_ch_check
    $error("channel count must match the two address bits");
  end

  assign pins_raw = '{cs_n: cs_n, sclk: sclk, serial_in: serial_in_power_down_pin,
                      pin_float: pin_float, load_strobe_n: load_strobe_n,
                      clear_n: clear_n};

  // every pin crosses together, so relative skew stays at the pin level
  pin_sync #(
    .WIDTH     ($bits(dac_ctrl_pkg::pin_type)),
    .RESET_VAL (dac_ctrl_pkg::PIN_RESET)
  ) u_pin_sync (
    .clk     (clk),
    .rst_n   (rst_n),
    .pin_in  (pins_raw),
    .pin_out (pins)
  );

  frame_shifter u_frame_shifter (
    .clk         (clk),
    .rst_n       (rst_n),
    .cs_n        (pins.cs_n),
    .sclk        (pins.sclk),
    .serial_in   (pins.serial_in),
    .frame       (frame),
    .frame_valid (frame_valid)
  );

  assign frame_addr = {frame.channel_addr_hi, frame.channel_addr_lo};
  assign frame_sel  = dac_ctrl_pkg::chan_select(frame_addr);

  always_comb begin
    nxt_state = state_ff;
    if (frame_valid) begin
      nxt_state.in_reg[frame_addr] = frame.code;
      for (int i = 0; i < NUM_CH; i++) begin
        // software power-down is sticky per channel until woken explicitly
        if (!frame.shutdown_all_flag) begin
          nxt_state.sw_pd[i] = 1'b1;
        end else if (frame_sel[i]) begin
          nxt_state.sw_pd[i] = !frame.shutdown_selected_flag;
        end
      end
    end
    // transparent load shows a code written in the same cycle
    if (!pins.load_strobe_n) begin
      nxt_state.dac_reg = nxt_state.in_reg;
    end
    // clear wins over a frame write and a load; power-down state is left alone
    if (!pins.clear_n) begin
      nxt_state.in_reg  = '0;
      nxt_state.dac_reg = '0;
    end
    // hardware power-down only gates outputs, codes stay put
    nxt_state.hw_pd   = pins.pin_float;
    nxt_state.chan_pd = nxt_state.sw_pd | {NUM_CH{nxt_state.hw_pd}};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= '{in_reg: {NUM_CH{dac_ctrl_pkg::CODE_RESET}},
                    dac_reg: {NUM_CH{dac_ctrl_pkg::CODE_RESET}},
                    sw_pd: dac_ctrl_pkg::PD_RESET, hw_pd: 1'b0,
                    chan_pd: dac_ctrl_pkg::PD_RESET};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign dac_code        = state_ff.dac_reg;
  assign input_code      = state_ff.in_reg;
  assign chan_power_down = state_ff.chan_pd;
  assign hw_power_down   = state_ff.hw_pd;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  input_write_a: assert property (
      (frame_valid && pins.clear_n)
      |=> input_code[$past(frame_addr)] == $past(frame.code))
    else $error("addressed input register not written");

  other_regs_a: assert property (
      (frame_valid && pins.clear_n && frame_addr == 2'h0)
      |=> $stable(input_code[1]) && $stable(input_code[2]) && $stable(input_code[3]))
    else $error("unaddressed input register changed");

  load_follow_a: assert property (
      (!pins.load_strobe_n && pins.clear_n && !frame_valid) |=> dac_code == input_code)
    else $error("dac registers not transparent during load");

  load_latch_a: assert property (
      (pins.load_strobe_n && pins.clear_n) |=> $stable(dac_code))
    else $error("dac registers moved with load strobe high");

  clear_zero_a: assert property (
      !pins.clear_n |=> (dac_code == '0) && (input_code == '0))
    else $error("clear did not zero the registers");

  all_down_a: assert property (
      (frame_valid && !frame.shutdown_all_flag) |=> chan_power_down == 4'hF)
    else $error("shutdown-all did not power down every channel");

  sel_down_a: assert property (
      (frame_valid && frame.shutdown_all_flag && !frame.shutdown_selected_flag)
      |=> state_ff.sw_pd == ($past(state_ff.sw_pd) | $past(frame_sel)))
    else $error("selected shutdown hit the wrong channels");

  chan_wake_a: assert property (
      (frame_valid && frame.shutdown_all_flag && frame.shutdown_selected_flag)
      |=> state_ff.sw_pd == ($past(state_ff.sw_pd) & ~$past(frame_sel)))
    else $error("wake frame did not restore only its channel");

  hw_down_a: assert property (
      $rose(pins.pin_float) |=> hw_power_down && (chan_power_down == 4'hF))
    else $error("floating pin did not force power-down");

  hw_keep_a: assert property (
      (hw_power_down && pins.load_strobe_n && pins.clear_n) |=> $stable(dac_code))
    else $error("codes changed during hardware power-down");

  hw_release_a: assert property (
      $fell(pins.pin_float) |=> !hw_power_down && (chan_power_down == state_ff.sw_pd))
    else $error("power-down pattern not restored after the pad was driven again");

  // one checker per channel: a frame for another address leaves this register alone
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_other_regs
    keep_other_a: assert property (
        (frame_valid && pins.clear_n && frame_addr != 2'(ch)) |=> $stable(input_code[ch]))
      else $error("unaddressed input register changed");
  end

  input_quiet_a: assert property (
      (!frame_valid && pins.clear_n) |=> $stable(input_code))
    else $error("input register changed without a frame");

  clear_keeps_pd_a: assert property (
      (!pins.clear_n && !frame_valid) |=> $stable(state_ff.sw_pd))
    else $error("clear disturbed the power-down state");

  // power-down only moves on a frame or on the pad; nothing else may touch it
  pd_persist_a: assert property (
      (!frame_valid && $stable(pins.pin_float)) |=> $stable(chan_power_down))
    else $error("channel power-down changed without a frame");

  frame_seen_c:  cover property (frame_valid && frame.shutdown_all_flag
                                 && frame.shutdown_selected_flag);
  load_pulse_c:  cover property ($fell(pins.load_strobe_n) ##[1:300] $rose(pins.load_strobe_n));
  sel_down_c:    cover property (frame_valid && frame.shutdown_all_flag
                                 && !frame.shutdown_selected_flag);
  clear_seen_c:  cover property ($fell(pins.clear_n));
  hw_down_c:     cover property ($rose(hw_power_down));

endmodule
`default_nettype wire

// ### src/dac_ctrl_pkg.sv
// package: constants, frame layout and carrier types of the quad dac serial load control
// assumes: one 50 MHz clock domain; all pin levels arrive asynchronously
`default_nettype none
package dac_ctrl_pkg;

  localparam int NUM_CH      = 4;
  localparam int CODE_W      = 8;
  localparam int ADDR_W      = 2;
  localparam int FRAME_W     = 12;
  localparam int SYNC_STAGES = 2;

  // frame bit positions, msb first on the wire
  localparam int SHUTDOWN_ALL_POS = 11;
  localparam int SHUTDOWN_SEL_POS = 10;
  localparam int ADDR_HI_POS      = 9;
  localparam int ADDR_LO_POS      = 8;
  localparam int CODE_MSB_POS     = 7;
  localparam int CODE_LSB_POS     = 0;

  localparam logic [CODE_W-1:0]  CODE_RESET  = 8'h00;
  localparam logic [FRAME_W-1:0] SHIFT_RESET = 12'h000;
  localparam logic [NUM_CH-1:0]  PD_RESET    = 4'h0;

  typedef logic [NUM_CH-1:0][CODE_W-1:0] code_bank_type;

  // field order matches bits 11 down to 0 of a frame
  typedef struct packed {
    logic              shutdown_all_flag;
    logic              shutdown_selected_flag;
    logic              channel_addr_hi;
    logic              channel_addr_lo;
    logic [CODE_W-1:0] code;
  } frame_type;

  // raw pin levels, grouped so they cross into the clock domain together
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic serial_in;
    logic pin_float;
    logic load_strobe_n;
    logic clear_n;
  } pin_type;

  localparam pin_type PIN_RESET = 6'h23;

  typedef enum logic [0:0] {
    FRAME_IDLE   = 1'b0,
    FRAME_ACTIVE = 1'b1
  } frame_state_type;

  function automatic logic [NUM_CH-1:0] chan_select(input logic [ADDR_W-1:0] addr);
    chan_select = 4'h1 << addr;
  endfunction

endpackage
`default_nettype wire

// ### src/pin_sync.sv
// two-stage synchroniser for a group of asynchronous pin levels
// assumes: inputs may change at any time relative to clk
`default_nettype none
module pin_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // levels
  input  wire logic [WIDTH-1:0] pin_in,
  output var  logic [WIDTH-1:0] pin_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] settled;
  } sync_state_type;

  sync_state_type state_ff;
  sync_state_type nxt_state;

  if (WIDTH < 1) begin : g_width_check
    $error("pin_sync needs at least one bit");
  end

  // the first stage is read only by the second
  always_comb begin
    nxt_state         = state_ff;
    nxt_state.meta    = pin_in;
    nxt_state.settled = state_ff.meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= {RESET_VAL, RESET_VAL};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign pin_out = state_ff.settled;

endmodule
`default_nettype wire

// ### src/frame_shifter.sv
// serial frame shifter: samples the link clock, shifts data while selected,
// hands the frame over when chip select returns high
// assumes: cs_n, sclk and serial_in are already synchronised to clk
`default_nettype none
module frame_shifter (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // synchronised link levels
  input  wire logic                  cs_n,
  input  wire logic                  sclk,
  input  wire logic                  serial_in,
  // frame hand-over
  output var  dac_ctrl_pkg::frame_type frame,
  output var  logic                  frame_valid
);

  typedef struct packed {
    dac_ctrl_pkg::frame_state_type        phase;
    logic                                 sclk_prev;
    logic [dac_ctrl_pkg::FRAME_W-1:0]     shift_reg;
    dac_ctrl_pkg::frame_type              frame;
    logic                                 frame_valid;
  } shifter_state_type;

  shifter_state_type state_ff;
  shifter_state_type nxt_state;
  logic              sclk_rise;

  assign sclk_rise = sclk && !state_ff.sclk_prev;

  always_comb begin
    nxt_state             = state_ff;
    nxt_state.sclk_prev   = sclk;
    nxt_state.frame_valid = 1'b0;
    // only the newest twelve bits survive a long frame
    if (!cs_n && sclk_rise) begin
      nxt_state.shift_reg = {state_ff.shift_reg[dac_ctrl_pkg::FRAME_W-2:0], serial_in};
    end
    case (state_ff.phase)
      dac_ctrl_pkg::FRAME_IDLE: begin
        if (!cs_n) begin
          nxt_state.phase = dac_ctrl_pkg::FRAME_ACTIVE;
        end
      end
      dac_ctrl_pkg::FRAME_ACTIVE: begin
        // sclk is held low by the host here, so no shift races the hand-over
        if (cs_n) begin
          nxt_state.frame       = dac_ctrl_pkg::frame_type'(state_ff.shift_reg);
          nxt_state.frame_valid = 1'b1;
          nxt_state.phase       = dac_ctrl_pkg::FRAME_IDLE;
        end
      end
      default: begin
        nxt_state.phase = dac_ctrl_pkg::FRAME_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= '{phase: dac_ctrl_pkg::FRAME_IDLE, sclk_prev: 1'b0,
                    shift_reg: dac_ctrl_pkg::SHIFT_RESET,
                    frame: dac_ctrl_pkg::frame_type'(dac_ctrl_pkg::SHIFT_RESET),
                    frame_valid: 1'b0};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign frame       = state_ff.frame;
  assign frame_valid = state_ff.frame_valid;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  shift_in_bit_a: assert property ((!cs_n && sclk_rise) |=>
      state_ff.shift_reg == {$past(state_ff.shift_reg[10:0]), $past(serial_in)})
    else $error("shift register did not advance by one bit");

  deselect_hold_a: assert property (cs_n |=> $stable(state_ff.shift_reg))
    else $error("shift register moved while deselected");

  frame_handover_a: assert property (
      (state_ff.phase == dac_ctrl_pkg::FRAME_ACTIVE && cs_n)
      |=> frame_valid && (frame == $past(state_ff.shift_reg)))
    else $error("frame not handed over on deselect");

endmodule
`default_nettype wire

// ### sim/spi_host_model.sv
// host side of the three-wire link: chip select, link clock, data and the floating pad
// assumes: link clock period 160 ns, free of the design clock; sclk idles low
`default_nettype none
module spi_host_model (
  // serial link
  output var logic cs_n,
  output var logic sclk,
  output var logic sdata,
  // pad floating indication
  output var logic pin_float
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    cs_n      = 1'b1;
    sclk      = 1'b0;
    sdata     = 1'b1;
    pin_float = 1'b0;
  end

  // n bits from bits[n-1] down to bits[0]; n = 0 gives a bare select pulse
  task automatic send(input logic [15:0] bits, input int n);
    cs_n = 1'b0;
    #63;
    for (int i = n - 1; i >= 0; i--) begin
      sdata = bits[i];
      #80;
      sclk = 1'b1;
      #80;
      sclk = 1'b0;
    end
    #40;
    cs_n = 1'b1;
    // released line: no pull, so show the inverse rather than a stale level
    sdata = ~sdata;
    #200;
  endtask

  // link clock pulses with chip select high
  task automatic idle_clocks(input int n);
    repeat (n) begin
      #80;
      sclk = 1'b1;
      #80;
      sclk = 1'b0;
    end
  endtask

  task automatic set_float(input logic v);
    pin_float = v;
    sdata     = ~sdata;
  endtask
endmodule
`default_nettype wire

// ### sim/quad_dac_serial_load_control_test.sv
// self-checking bench of the quad dac serial load control
// assumes: the host model drives the link pins; load and clear are driven here
`default_nettype none
`define CHK(got, exp) begin \
  compares++; \
  if ((got) !== (exp)) begin \
    n_fail++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end
module quad_dac_serial_load_control_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic                        clk;
  logic                        rst_n;
  logic                        cs_n;
  logic                        sclk;
  logic                        sdata;
  logic                        pin_float;
  logic                        load_strobe_n;
  logic                        clear_n;
  dac_ctrl_pkg::code_bank_type dac_code;
  dac_ctrl_pkg::code_bank_type input_code;
  logic [3:0]                  chan_power_down;
  logic                        hw_power_down;
  dac_ctrl_pkg::code_bank_type exp_in;
  dac_ctrl_pkg::code_bank_type exp_dac;
  logic [3:0]                  exp_pd;
  int                          n_fail;
  int                          compares;

  spi_host_model host (
    .cs_n      (cs_n),
    .sclk      (sclk),
    .sdata     (sdata),
    .pin_float (pin_float)
  );

  quad_dac_serial_load_control #(.NUM_CH(4)) uut (
    .clk                      (clk),
    .rst_n                    (rst_n),
    .cs_n                     (cs_n),
    .sclk                     (sclk),
    .serial_in_power_down_pin (sdata),
    .pin_float                (pin_float),
    .load_strobe_n            (load_strobe_n),
    .clear_n                  (clear_n),
    .dac_code                 (dac_code),
    .chan_power_down          (chan_power_down),
    .hw_power_down            (hw_power_down),
    .input_code               (input_code)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic results();
    if (n_fail == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // load at the next frame is four edges after select rises; six leaves margin
  task automatic settle();
    repeat (6) @(posedge clk);
    #1;
    `CHK(input_code, exp_in)
    `CHK(chan_power_down, exp_pd)
    `CHK(dac_code, exp_dac)
  endtask

  task automatic expect_frame(input logic [11:0] f);
    exp_in[f[9:8]] = f[7:0];
    if (!f[11]) begin
      exp_pd = 4'hF;
    end else if (!f[10]) begin
      exp_pd[f[9:8]] = 1'b1;
    end else begin
      exp_pd[f[9:8]] = 1'b0;
    end
    if (!load_strobe_n) begin
      exp_dac = exp_in;
    end
    settle();
  endtask

  task automatic frame(input logic [11:0] f);
    host.send({4'h0, f}, 12);
    expect_frame(f);
  endtask

  task automatic drive_load(input logic v);
    @(posedge clk);
    #1;
    load_strobe_n = v;
    if (!v) begin
      exp_dac = exp_in;
    end
    settle();
  endtask

  // every address once, dac registers stay latched with load high
  task automatic t_channels();
    for (int ch = 0; ch < 4; ch++) begin
      frame({4'hC | ch[3:0], 8'h3C + 8'(ch * 8'h41)});
    end
  endtask

  task automatic t_load();
    drive_load(1'b0);
    frame(12'hC5A);
    drive_load(1'b1);
    frame(12'hCC3);
  endtask

  task automatic t_power();
    frame(12'h510);
    frame(12'hD20);
    frame(12'hE30);
    frame(12'hA31);
    frame(12'hF40);
    frame(12'hE32);
  endtask

  // clocks with select high must not move the shift register; a short frame
  // then keeps the old low nibble as its flags and address
  task automatic t_idle_shift();
    frame(12'hFEF);
    host.idle_clocks(3);
    host.send(16'h007E, 8);
    expect_frame(12'hF7E);
    host.send(16'h1C81, 14);
    expect_frame(12'hC81);
  endtask

  task automatic t_clear();
    @(posedge clk);
    #1;
    clear_n = 1'b0;
    exp_in  = '0;
    exp_dac = '0;
    settle();
    clear_n = 1'b1;
    host.send(16'h0000, 0);
    expect_frame(12'hC81);
  endtask

  task automatic t_float();
    host.set_float(1'b1);
    repeat (6) @(posedge clk);
    #1;
    `CHK(hw_power_down, 1'b1)
    `CHK(chan_power_down, 4'hF)
    `CHK(dac_code, exp_dac)
    `CHK(input_code, exp_in)
    host.set_float(1'b0);
    settle();
    `CHK(hw_power_down, 1'b0)
  endtask

  initial begin
    n_fail        = 0;
    compares      = 0;
    rst_n         = 1'b0;
    load_strobe_n = 1'b1;
    clear_n       = 1'b1;
    exp_in        = '0;
    exp_dac       = '0;
    exp_pd        = 4'h0;
    repeat (20) @(posedge clk);
    #1;
    rst_n = 1'b1;
    settle();
    t_channels();
    t_load();
    t_power();
    t_idle_shift();
    t_clear();
    t_float();
    results();
  end
endmodule
`default_nettype wire
